/* File: logic/sclkr_pkg.sv */
// constants and carrier types for the suspend clock and refresh block
package sclkr_pkg;

  // ****************************************************************
  // codes and timing
  // ****************************************************************
  localparam int CODE_W = 5;
  localparam logic [CODE_W-1:0] CODE_SUSPEND = 5'h15;
  localparam logic [CODE_W-1:0] CODE_RESUME = 5'h16;
  localparam int CLK_PERIOD_NS = 40;
  localparam int REFRESH_WIDTH_NS = 1000;
  localparam int REFRESH_TOL_NS = 500;
  // one refresh per half period of the timekeeping crystal
  localparam int REFRESH_PERIOD_NS = 15260;
  localparam int REFRESH_CYCLES = REFRESH_WIDTH_NS / CLK_PERIOD_NS;
  localparam int REFRESH_CNT_W = $clog2(REFRESH_CYCLES + 1);
  localparam logic [CODE_W-1:0] CODE_RESET = 5'h00;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  // peripheral selects, active low
  typedef struct packed {
    logic serial_a_select_n;
    logic serial_b_select_n;
    logic parallel_select_n;
  } sclkr_sel_t;

  localparam sclkr_sel_t SEL_IDLE = 3'h7;

  typedef enum logic [1:0] {
    CK_FAST,
    CK_PARK_SLOW,
    CK_SLOW,
    CK_PARK_FAST
  } sclkr_ck_t;

endpackage

/* File: logic/sclkr_top.sv */
// suspend entry and exit, system clock source switch, suspend dram refresh
`timescale 1ns/100ps
module sclkr_top
  import sclkr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_fast_crystal,
  input wire logic i_timekeeping_crystal,
  input wire logic [CODE_W-1:0] i_select_code_lines,
  input wire logic i_decode_enable_n,
  input wire logic i_io_write_n,
  input wire sclkr_sel_t i_decoded_sel,
  output logic o_system_clock_out,
  output logic o_suspend_refresh_pulse,
  output sclkr_sel_t o_sel,
  output logic o_periph_clk_en,
  output logic o_suspended,
  output logic [CODE_W-1:0] o_latched_code
);

  // ****************************************************************
  // state
  // ****************************************************************
  // clock source switch
  sclkr_ck_t ck_q;
  sclkr_ck_t ck_d;
  logic out_q;
  logic out_d;
  logic out_prev_q;
  // suspend latch
  logic susp_q;
  logic susp_d;
  logic [CODE_W-1:0] code_q;
  logic [CODE_W-1:0] code_d;
  sclkr_sel_t sel_q;
  sclkr_sel_t sel_d;
  // refresh
  logic slow_prev_q;
  logic [REFRESH_CNT_W-1:0] ref_cnt_q;
  logic [REFRESH_CNT_W-1:0] ref_cnt_d;
  logic ref_q;

  // ****************************************************************
  // code qualification
  // ****************************************************************
  // true when the code lines carry the given code
  function automatic logic code_is(
    input logic [CODE_W-1:0] lines,
    input logic [CODE_W-1:0] want
  );
    return lines == want;
  endfunction

  // clock out history: a fall is seen one cycle after it is launched
  wire out_fall;
  wire code_suspend_seen;
  wire code_resume_seen;
  wire strobe_active;
  wire enter_hit;
  wire exit_hit;
  wire slow_edge;
  assign out_fall = out_prev_q & ~out_q;
  assign code_suspend_seen = code_is(i_select_code_lines, CODE_SUSPEND);
  assign code_resume_seen = code_is(i_select_code_lines, CODE_RESUME);
  assign strobe_active = ~i_decode_enable_n & ~i_io_write_n;
  assign enter_hit = out_fall & code_suspend_seen & strobe_active;
  assign exit_hit = out_fall & code_resume_seen;
  // any change of the slow crystal marks one half period
  assign slow_edge = i_timekeeping_crystal ^ slow_prev_q;

  // ****************************************************************
  // suspend latch
  // ****************************************************************
  // codes off a clock fall, or the wrong code for the state, are ignored
  // selects are latched from the live decode of the entry cycle
  always_comb begin
    susp_d = susp_q;
    code_d = code_q;
    sel_d = sel_q;
    if (!susp_q && enter_hit) begin
      susp_d = 1'b1;
      code_d = i_select_code_lines;
      sel_d = i_decoded_sel;
    end else if (susp_q && exit_hit) begin
      susp_d = 1'b0;
      code_d = CODE_RESET;
      sel_d = SEL_IDLE;
    end
  end

  // ****************************************************************
  // clock source switch
  // ****************************************************************
  // the switch only starts while clock out is low, and each park state
  // waits for the new source to be low too, so no short high phase can
  // reach the system controller in either direction
  always_comb begin
    ck_d = ck_q;
    out_d = out_q;
    case (ck_q)
      CK_FAST: begin
        out_d = i_fast_crystal;
        if (susp_q && !out_q) begin
          ck_d = CK_PARK_SLOW;
          out_d = 1'b0;
        end
      end
      // park low until slow source is low
      CK_PARK_SLOW: begin
        out_d = 1'b0;
        if (!i_timekeeping_crystal) begin
          ck_d = CK_SLOW;
        end
      end
      CK_SLOW: begin
        out_d = i_timekeeping_crystal;
        if (!susp_q && !out_q) begin
          ck_d = CK_PARK_FAST;
          out_d = 1'b0;
        end
      end
      // park low until fast source is low
      CK_PARK_FAST: begin
        out_d = 1'b0;
        if (!i_fast_crystal) begin
          ck_d = CK_FAST;
        end
      end
      default: begin
        ck_d = CK_FAST;
        out_d = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // refresh pulse
  // ****************************************************************
  // a pulse already running when suspend ends is allowed to finish,
  // so the dram never sees a runt refresh
  wire ref_start;
  wire ref_running;
  wire ref_busy_next;
  assign ref_start = susp_q & slow_edge;
  assign ref_running = (ref_cnt_q != '0);
  assign ref_busy_next = (ref_cnt_d != '0);

  always_comb begin
    ref_cnt_d = ref_cnt_q;
    // one pulse per slow half period
    if (ref_start) begin
      ref_cnt_d = REFRESH_CNT_W'(REFRESH_CYCLES);
    end else if (ref_running) begin
      ref_cnt_d = ref_cnt_q - 1'b1;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // clock source state and the registered clock out
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ck_q <= CK_FAST;
      out_q <= 1'b0;
      out_prev_q <= 1'b0;
    end else begin
      ck_q <= ck_d;
      out_q <= out_d;
      out_prev_q <= out_q;
    end
  end

  // suspend flag, latched code and held selects
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      susp_q <= 1'b0;
      code_q <= CODE_RESET;
      sel_q <= SEL_IDLE;
    end else begin
      susp_q <= susp_d;
      code_q <= code_d;
      sel_q <= sel_d;
    end
  end

  // slow crystal history and refresh pulse counter
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slow_prev_q <= 1'b0;
      ref_cnt_q <= '0;
      ref_q <= 1'b0;
    end else begin
      slow_prev_q <= i_timekeeping_crystal;
      ref_cnt_q <= ref_cnt_d;
      ref_q <= ref_busy_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_system_clock_out = out_q;
  assign o_suspend_refresh_pulse = ref_q;
  // held selects are and-ed with live decode
  wire sclkr_sel_t sel_hold;
  assign sel_hold = sel_q & i_decoded_sel;
  assign o_sel = susp_q ? sel_hold : i_decoded_sel;
  assign o_periph_clk_en = ~susp_q;
  assign o_suspended = susp_q;
  assign o_latched_code = code_q;

endmodule

/* File: verif/sclkr_asserts.sv */
// checker on the suspend clock and refresh ports
`timescale 1ns/100ps
module sclkr_asserts import sclkr_pkg::*; (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_decode_enable_n,
  input wire logic i_io_write_n,
  input wire logic o_system_clock_out,
  input wire logic o_suspend_refresh_pulse,
  input wire logic o_periph_clk_en,
  input wire logic o_suspended,
  input wire logic [CODE_W-1:0] i_select_code_lines,
  input wire logic [CODE_W-1:0] o_latched_code,
  input wire sclkr_sel_t i_decoded_sel,
  input wire sclkr_sel_t o_sel
);
  logic [4:0] hi_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) hi_q <= 5'h00;
    else hi_q <= o_suspend_refresh_pulse ? hi_q + 5'h01 : 5'h00;
  end
  sequence s_fall;
    $fell(o_system_clock_out);
  endsequence
  a_entry_take: assert property (
    s_fall ##0 (!o_suspended && !i_decode_enable_n && !i_io_write_n && i_select_code_lines
    == CODE_SUSPEND) |=> o_suspended && o_latched_code == CODE_SUSPEND) else $error("entry");
  a_exit_take: assert property (
    s_fall ##0 (o_suspended && i_select_code_lines == CODE_RESUME) |=> !o_suspended &&
    o_latched_code == CODE_RESET) else $error("exit");
  a_on_fall: assert property (
    $changed(o_suspended) |-> $past(o_system_clock_out, 2) && !$past(o_system_clock_out))
    else $error("off fall");
  a_periph_en: assert property (o_periph_clk_en != o_suspended) else $error("en");
  a_sel_live: assert property (!o_suspended |-> o_sel == i_decoded_sel) else $error("sel");
  a_sel_keep: assert property (
    $rose(o_suspended) |-> (o_sel & ~$past(i_decoded_sel)) == 3'h0) else $error("hold");
  a_ref_gate: assert property (
    $rose(o_suspend_refresh_pulse) |-> $past(o_suspended) || $past(o_suspended, 2))
    else $error("refresh");
  a_ref_width: assert property (
    $fell(o_suspend_refresh_pulse) |-> hi_q == 5'(REFRESH_CYCLES)) else $error("width");
endmodule
bind sclkr_top sclkr_asserts sclkr_asserts_i (.*);

/* File: verif/sclkr_ctrl.sv */
// controller model: holds a code and strobes until clock out falls
`timescale 1ns/100ps
module sclkr_ctrl import sclkr_pkg::*; (
  input wire logic i_clk, i_ck, i_go,
  input wire logic [CODE_W-1:0] i_code,
  output logic [CODE_W-1:0] o_code = 5'h00,
  output logic o_busy = 1'b0
);
  logic p_q = 1'b0;
  always @(posedge i_clk) begin
    p_q <= i_ck;
    if (i_go) o_busy <= 1'b1;
    else if (p_q && !i_ck) o_busy <= 1'b0;
    // idle lines wander, never 15H or 16H
    o_code <= i_go || o_busy ? i_code : {1'b0, o_code[2:0], ~o_code[3]};
  end
endmodule

/* File: verif/suspend_clock_refresh_tb.sv */
// bench for the suspend clock and refresh block
`timescale 1ns/100ps
module suspend_clock_refresh_tb;
  import sclkr_pkg::*;
  logic i_clk = 0, i_arst_n = 0, fast = 0, slow = 0, go = 0, busy, ck, pul, pen, su, su_q = 0;
  logic [CODE_W-1:0] code = 5'h00, cl, lat;
  sclkr_sel_t dsel = SEL_IDLE;
  sclkr_sel_t osel;
  int seed = 61, fail_count = 0, tests_run = 0, n, m, div = 0;
  logic [CODE_W:0] notes[$];
  initial forever #20 i_clk = ~i_clk;
  sclkr_top sclkr_top_i (.i_clk, .i_arst_n, .i_fast_crystal(fast), .i_timekeeping_crystal(slow),
    .i_select_code_lines(cl), .i_decode_enable_n(~busy), .i_io_write_n(~busy),
    .i_decoded_sel(dsel), .o_system_clock_out(ck), .o_suspend_refresh_pulse(pul), .o_sel(osel),
    .o_periph_clk_en(pen), .o_suspended(su), .o_latched_code(lat));
  sclkr_ctrl sclkr_ctrl_i (.i_clk, .i_ck(ck), .i_go(go), .i_code(code), .o_code(cl), .o_busy(busy));
  task automatic chk(string s, logic [CODE_W:0] e, g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic span(int c);
    logic a, b;
    n = 0;
    m = 0;
    @(negedge i_clk);
    repeat (c) begin
      a = ck;
      b = pul;
      @(negedge i_clk);
      n += int'(ck & ~a);
      m += int'(pul & ~b);
      if (!su) chk("sel", {3'h0, dsel}, {3'h0, osel});
    end
  endtask
  task automatic send(logic [CODE_W-1:0] c);
    @(posedge i_clk);
    code <= c;
    go <= 1;
    @(posedge i_clk);
    go <= 0;
    repeat (800) begin
      @(posedge i_clk);
      if (!busy) break;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // crystals: fast sampled near rate, slow toggles every 381 cycles
  always @(posedge i_clk) begin
    fast <= ~fast;
    dsel <= sclkr_sel_t'(3'($random(seed)));
    div <= div == 380 ? 0 : div + 1;
    slow <= slow ^ (div == 380);
    su_q <= su;
    if (i_arst_n && su !== su_q) chk("state", notes.size() ? notes.pop_front() : 6'h3F, {~pen, lat});
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1;
    repeat (2) @(posedge i_clk);
    send(CODE_RESUME);
    span(100);
    chk("fast", 6'd50, 6'(n));
    $display("test fast end");
    notes.push_back({1'b1, CODE_SUSPEND});
    send(CODE_SUSPEND);
    span(800);
    span(1524);
    chk("slow", 6'd2, 6'(n));
    chk("refresh", 6'd4, 6'(m));
    send(CODE_SUSPEND);
    $display("test suspend end");
    notes.push_back({1'b0, CODE_RESET});
    send(CODE_RESUME);
    span(30);
    span(800);
    chk("idle", 6'h00, 6'(m + notes.size()));
    span(100);
    chk("refast", 6'd50, 6'(n));
    $display("test resume end");
    give_verdict();
  end
  initial begin
    #800000;
    fail_count++;
    give_verdict();
  end
endmodule
